// File: tc_chan.sv
`include "tc_chan_regs.svh"
`default_nettype none
module tc_chan
   import tc_chan_pkg::*;
(
   input wire logic clk_i, // 250 MHz
   input wire logic reset_i, // Sync, active high
   input wire bus_req_t bus_i, // Register request
   output logic [31:0] rdata_o, // Read data, cycle after strobe
   input wire core_evt_t core_i, // Counter core signals
   input wire logic line_a_pin_i, // line_a pin level, async
   input wire logic line_b_pin_i, // line_b pin level, async
   output logic line_b_o, // line_b drive level
   output logic line_b_oe_o, // line_b drive enable
   output logic wave_mode_o, // Waveform mode selected
   output logic irq_o // Level interrupt
);

   // ==========================================================
   // Flag bit numbering
   localparam int F_OVF = 0;
   localparam int F_DBL = 1;
   localparam int F_MA = 2;
   localparam int F_MB = 3;
   localparam int F_MC = 4;
   localparam int F_LA = 5;
   localparam int F_LB = 6;
   localparam int F_EXT = 7;

   // Flags shown in the current mode
   function automatic logic [7:0] view_mask(input logic wave);
      view_mask = wave ? `TC_VIEW_WAVE : `TC_VIEW_CAPT;
   endfunction

   // Equality of a bus address with an offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Next line level under a trigger effect code
   function automatic logic apply_eff(input trig_eff_t e, input logic lvl);
      case (e)
         EFF_SET: apply_eff = 1'b1;
         EFF_CLEAR: apply_eff = 1'b0;
         EFF_TOGGLE: apply_eff = ~lvl;
         default: apply_eff = lvl;
      endcase
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [1:0] line_a_sync_r;
   logic [1:0] line_b_sync_r;
   logic [1:0] line_a_sync_nxt;
   logic [1:0] line_b_sync_nxt;

   // Two stages; only stage 1 is read elsewhere
   always_comb begin
      line_a_sync_nxt = {line_a_sync_r[0], line_a_pin_i};
      line_b_sync_nxt = {line_b_sync_r[0], line_b_pin_i};
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         line_a_sync_r <= 2'h0;
         line_b_sync_r <= 2'h0;
      end else begin
         line_a_sync_r <= line_a_sync_nxt;
         line_b_sync_r <= line_b_sync_nxt;
      end
   end

   // ==========================================================
   // Decode
   logic wr_ctrl, wr_cmd, wr_cmp_a, wr_cmp_b, wr_cmp_c, wr_ier, wr_idr, wr_icr;
   logic rd_sr, rd_cmp_a, rd_cmp_b;

   // Strobe qualified by address
   always_comb begin
      wr_ctrl = bus_i.wr && hit(bus_i.addr, `TC_OFS_CTRL);
      wr_cmd = bus_i.wr && hit(bus_i.addr, `TC_OFS_CMD);
      wr_cmp_a = bus_i.wr && hit(bus_i.addr, `TC_OFS_CMP_A);
      wr_cmp_b = bus_i.wr && hit(bus_i.addr, `TC_OFS_CMP_B);
      wr_cmp_c = bus_i.wr && hit(bus_i.addr, `TC_OFS_CMP_C);
      wr_ier = bus_i.wr && hit(bus_i.addr, `TC_OFS_IER);
      wr_idr = bus_i.wr && hit(bus_i.addr, `TC_OFS_IDR);
      wr_icr = bus_i.wr && hit(bus_i.addr, `TC_OFS_ICR);
      rd_sr = bus_i.rd && hit(bus_i.addr, `TC_OFS_SR);
      rd_cmp_a = bus_i.rd && hit(bus_i.addr, `TC_OFS_CMP_A);
      rd_cmp_b = bus_i.rd && hit(bus_i.addr, `TC_OFS_CMP_B);
   end

   // ==========================================================
   // Control and compare registers
   logic wave_r, wave_nxt;
   trig_eff_t eff_r, eff_nxt;
   logic line_b_r, line_b_nxt;
   logic [15:0] cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt, cmp_c_r, cmp_c_nxt;

   // Capture loads win over nothing: software cannot write A/B then
   always_comb begin
      wave_nxt = wave_r;
      eff_nxt = eff_r;
      line_b_nxt = line_b_r;
      cmp_a_nxt = cmp_a_r;
      cmp_b_nxt = cmp_b_r;
      cmp_c_nxt = cmp_c_r;
      if (wr_ctrl) begin
         wave_nxt = bus_i.wdata[`TC_CTRL_WAVE];
         eff_nxt = trig_eff_t'(bus_i.wdata[`TC_CTRL_EFF_LO +: 2]);
      end
      if (wr_cmd && bus_i.wdata[`TC_CMD_SWTRG] && wave_r) begin
         line_b_nxt = apply_eff(eff_r, line_b_r);
      end
      if (!wave_r) begin
         if (core_i.load_a) begin
            cmp_a_nxt = core_i.count;
         end
         if (core_i.load_b) begin
            cmp_b_nxt = core_i.count;
         end
      end else begin
         if (wr_cmp_a) begin
            cmp_a_nxt = bus_i.wdata[15:0];
         end
         if (wr_cmp_b) begin
            cmp_b_nxt = bus_i.wdata[15:0];
         end
      end
      if (wr_cmp_c) begin
         cmp_c_nxt = bus_i.wdata[15:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wave_r <= 1'b0;
         eff_r <= EFF_NONE;
         line_b_r <= 1'b0;
         cmp_a_r <= 16'h0000;
         cmp_b_r <= 16'h0000;
         cmp_c_r <= 16'h0000;
      end else begin
         wave_r <= wave_nxt;
         eff_r <= eff_nxt;
         line_b_r <= line_b_nxt;
         cmp_a_r <= cmp_a_nxt;
         cmp_b_r <= cmp_b_nxt;
         cmp_c_r <= cmp_c_nxt;
      end
   end

   // ==========================================================
   // Events, sticky flags and unread tracking
   logic [7:0] ev, flags_r, flags_nxt, clr;
   logic unread_a_r, unread_a_nxt, unread_b_r, unread_b_nxt;
   logic cap_a, cap_b;

   // Event decode from the core and compares
   always_comb begin
      cap_a = !wave_r && core_i.load_a;
      cap_b = !wave_r && core_i.load_b;
      ev = 8'h00;
      ev[F_OVF] = core_i.overflow;
      ev[F_DBL] = (cap_a && unread_a_r) || (cap_b && unread_b_r);
      ev[F_MA] = wave_r && core_i.tick && (core_i.count == cmp_a_r);
      ev[F_MB] = wave_r && core_i.tick && (core_i.count == cmp_b_r);
      ev[F_MC] = core_i.tick && (core_i.count == cmp_c_r);
      ev[F_LA] = cap_a;
      ev[F_LB] = cap_b;
      ev[F_EXT] = core_i.ext_trig;
   end

   // Set beats clear so no event slips through a read
   always_comb begin
      clr = 8'h00;
      if (rd_sr) begin
         clr = 8'hFF;
      end else if (wr_icr) begin
         clr = bus_i.wdata[7:0];
      end
      flags_nxt = (flags_r & ~clr) | ev;
      unread_a_nxt = cap_a || (unread_a_r && !rd_cmp_a);
      unread_b_nxt = cap_b || (unread_b_r && !rd_cmp_b);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flags_r <= 8'h00;
         unread_a_r <= 1'b0;
         unread_b_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         unread_a_r <= unread_a_nxt;
         unread_b_r <= unread_b_nxt;
      end
   end

   // ==========================================================
   // Interrupt enables
   logic [7:0] en_r, en_nxt;

   // Disable applied after enable when both touch a bit
   always_comb begin
      en_nxt = en_r;
      if (wr_ier) begin
         en_nxt = en_nxt | bus_i.wdata[7:0];
      end
      if (wr_idr) begin
         en_nxt = en_nxt & ~bus_i.wdata[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         en_r <= 8'h00;
      end else begin
         en_r <= en_nxt;
      end
   end

   // ==========================================================
   // Read mux and line outputs
   logic [31:0] rdata_r, rdata_nxt;
   logic [7:0] flags_view;
   logic line_a_lvl, line_b_lvl;

   // Mirrors: pin in capture, driven level in waveform
   always_comb begin
      flags_view = flags_r & view_mask(wave_r);
      line_a_lvl = wave_r ? core_i.wave_a_level : line_a_sync_r[1];
      line_b_lvl = wave_r ? line_b_r : line_b_sync_r[1];
      rdata_nxt = 32'h0000_0000;
      if (bus_i.rd) begin
         case (bus_i.addr)
            `TC_OFS_CTRL: rdata_nxt = {28'h0, eff_r, 1'b0, wave_r};
            `TC_OFS_COUNT: rdata_nxt = {`TC_ZERO16, core_i.count};
            `TC_OFS_CMP_A: rdata_nxt = {`TC_ZERO16, cmp_a_r};
            `TC_OFS_CMP_B: rdata_nxt = {`TC_ZERO16, cmp_b_r};
            `TC_OFS_CMP_C: rdata_nxt = {`TC_ZERO16, cmp_c_r};
            `TC_OFS_SR: begin
               rdata_nxt[7:0] = flags_view;
               rdata_nxt[`CHANNEL_FLAGS_REG_CLKRUN] = core_i.clk_running;
               rdata_nxt[`CHANNEL_FLAGS_REG_LINEA] = line_a_lvl;
               rdata_nxt[`CHANNEL_FLAGS_REG_LINEB] = line_b_lvl;
            end
            `TC_OFS_IMR: rdata_nxt = {24'h000000, en_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs
   assign rdata_o = rdata_r;
   assign line_b_o = line_b_r;
   assign line_b_oe_o = wave_r;
   assign wave_mode_o = wave_r;
   assign irq_o = |(flags_r & view_mask(wave_r) & en_r);

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_trig_toggle;
      wr_cmd && bus_i.wdata[`TC_CMD_SWTRG] && wave_r && eff_r == EFF_TOGGLE;
   endsequence

   sequence s_trig_set;
      wr_cmd && bus_i.wdata[`TC_CMD_SWTRG] && wave_r && eff_r == EFF_SET;
   endsequence

   sequence s_sr_read_quiet;
      rd_sr && !core_i.overflow ##1 !core_i.overflow;
   endsequence

   a_trig_toggle_line: assert property (s_trig_toggle |=> line_b_o != $past(line_b_o))
      else $error("soft trigger toggle did not invert line_b");
   a_trig_set_line: assert property (s_trig_set |=> line_b_o)
      else $error("soft trigger set left line_b low");
   a_count_readback: assert property (bus_i.rd && hit(bus_i.addr, `TC_OFS_COUNT)
      |=> rdata_o == {`TC_ZERO16, $past(core_i.count)})
      else $error("counter value read mismatch");
   a_cmpa_write_blocked: assert property (wr_cmp_a && !wave_r && !core_i.load_a
      |=> cmp_a_r == $past(cmp_a_r))
      else $error("compare_a written in capture mode");
   a_cmpa_write_taken: assert property (wr_cmp_a && wave_r
      |=> cmp_a_r == $past(bus_i.wdata[15:0]))
      else $error("compare_a write lost in waveform mode");
   a_cmpb_write_blocked: assert property (wr_cmp_b && !wave_r && !core_i.load_b
      |=> cmp_b_r == $past(cmp_b_r))
      else $error("compare_b written in capture mode");
   a_cmpb_write_taken: assert property (wr_cmp_b && wave_r
      |=> cmp_b_r == $past(bus_i.wdata[15:0]))
      else $error("compare_b write lost in waveform mode");
   a_cmpc_write_taken: assert property (wr_cmp_c |=> cmp_c_r == $past(bus_i.wdata[15:0]))
      else $error("compare_c write lost");
   a_ovf_read_clear: assert property (s_sr_read_quiet |-> !flags_r[F_OVF])
      else $error("overflow flag survived status read");
   a_ovf_sticky: assert property (core_i.overflow ##1 !rd_sr && !wr_icr |=> flags_r[F_OVF])
      else $error("overflow flag not sticky");
   a_dbl_load_set: assert property (cap_a && unread_a_r |=> flags_r[F_DBL])
      else $error("double load not flagged");
   a_match_hidden_cap: assert property (rd_sr && !wave_r |=> rdata_o[3:2] == 2'h0)
      else $error("match a/b visible in capture mode");
   a_match_a_set: assert property (wave_r && core_i.tick && core_i.count == cmp_a_r
      |=> flags_r[F_MA])
      else $error("match_a not flagged");
   a_match_c_set: assert property (core_i.tick && core_i.count == cmp_c_r |=> flags_r[F_MC])
      else $error("match_c not flagged");
   a_load_a_set: assert property (cap_a |=> flags_r[F_LA])
      else $error("load_a not flagged");
   a_load_hidden_wave: assert property (rd_sr && wave_r |=> rdata_o[6:5] == 2'h0)
      else $error("load flags visible in waveform mode");
   a_ext_flag_set: assert property (core_i.ext_trig |=> flags_r[F_EXT])
      else $error("external trigger not flagged");
   a_ext_write_clear: assert property (wr_icr && bus_i.wdata[F_EXT] && !core_i.ext_trig
      |=> !flags_r[F_EXT])
      else $error("external trigger flag not cleared by write");
   a_clk_run_mirror: assert property (rd_sr |=> rdata_o[16] == $past(core_i.clk_running))
      else $error("clock running bit wrong");
   a_line_b_mirror: assert property (rd_sr && wave_r |=> rdata_o[18] == $past(line_b_r))
      else $error("line_b mirror wrong in waveform mode");
   a_enable_set: assert property (wr_ier && !wr_idr
      |=> (en_r & $past(bus_i.wdata[7:0])) == $past(bus_i.wdata[7:0]))
      else $error("enable write did not set enables");
   a_disable_clr: assert property (wr_idr |=> (en_r & $past(bus_i.wdata[7:0])) == 8'h00)
      else $error("disable write did not clear enables");
   a_mask_read: assert property (bus_i.rd && hit(bus_i.addr, `TC_OFS_IMR)
      |=> rdata_o[7:0] == $past(en_r))
      else $error("mask read mismatch");
   a_irq_level: assert property (flags_r[F_OVF] && en_r[F_OVF] |-> irq_o)
      else $error("interrupt low with enabled overflow flag");
   a_irq_quiet: assert property (en_r == 8'h00 |-> !irq_o)
      else $error("interrupt high with all sources disabled");
   a_event_over_read: assert property (rd_sr && core_i.ext_trig |=> flags_r[F_EXT])
      else $error("event lost on status read");

endmodule
`default_nettype wire

// File: tc_chan_regs.svh
// Overview of operation
// - Soft trigger field sets, clears, toggles line_b, waveform mode only
// - Counter value reads live 16-bit count
// - compare_a writable only in waveform mode
// - compare_b writable only in waveform mode
// - compare_c writable in both modes
// - Overflow flag sticky until status read or clear register write
// - Double load flag, capture mode only
// - Match a/b flags, waveform mode only
// - Match c flag in both modes
// - Load a/b flags, capture mode only
// - External trigger flag clears on status read
// - Bit 16 shows counter clock running
// - Bits 17/18 mirror line_a and line_b
// - Enable register sets enables on ones
// - Disable register clears enables on ones
// - Mask register reads current enables
// - waveform_select picks waveform or capture mode
`ifndef TC_CHAN_REGS_SVH
`define TC_CHAN_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define TC_OFS_CTRL 8'h00
`define TC_OFS_CMD 8'h04
`define TC_OFS_COUNT 8'h10
`define TC_OFS_CMP_A 8'h14
`define TC_OFS_CMP_B 8'h18
`define TC_OFS_CMP_C 8'h1C
`define TC_OFS_SR 8'h20
`define TC_OFS_IER 8'h24
`define TC_OFS_IDR 8'h28
`define TC_OFS_IMR 8'h2C
`define TC_OFS_ICR 8'h30
// ==========================================================
// Field positions
`define TC_CTRL_WAVE 0
`define TC_CTRL_EFF_LO 2
`define TC_CMD_SWTRG 0
`define CHANNEL_FLAGS_REG_CLKRUN 16
`define CHANNEL_FLAGS_REG_LINEA 17
`define CHANNEL_FLAGS_REG_LINEB 18
// ==========================================================
// Flags visible per mode
`define TC_VIEW_WAVE 8'h9D
`define TC_VIEW_CAPT 8'hF3
`define TC_ZERO16 16'h0000
`endif

// File: tc_chan_pkg.sv
`default_nettype none
package tc_chan_pkg;
   // ==========================================================
   // Bus request from the register master
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   // ==========================================================
   // Signals from the counter core, same clock
   typedef struct packed {
      logic [15:0] count;
      logic tick;
      logic overflow;
      logic load_a;
      logic load_b;
      logic ext_trig;
      logic clk_running;
      logic wave_a_level;
   } core_evt_t;
   // ==========================================================
   // Software trigger effect codes
   typedef enum logic [1:0] {
      EFF_NONE = 2'h0,
      EFF_SET = 2'h1,
      EFF_CLEAR = 2'h2,
      EFF_TOGGLE = 2'h3
   } trig_eff_t;
endpackage
`default_nettype wire

// File: tb_top.sv
`include "tc_chan_regs.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tc_chan_pkg::*;
   // ==========================================================
   // Stimulus, model state and counters
   logic clk_i, reset_i, pin_a, pin_b, line_b, line_b_oe, wave_mode, irq;
   logic [31:0] rdata, d;
   bus_req_t bus;
   core_evt_t core;
   int errors, num_checks;
   logic [15:0] rnd, v;
   logic [15:0] cmp [3];
   logic [7:0] flags_m, ien_m;
   logic wave_m, lb_m;
   tc_chan dut_u (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata), .core_i(core),
      .line_a_pin_i(pin_a), .line_b_pin_i(pin_b), .line_b_o(line_b), .line_b_oe_o(line_b_oe),
      .wave_mode_o(wave_mode), .irq_o(irq));
   // ==========================================================
   // Clock, 4 ns period
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ==========================================================
   // Expectation helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Flags hidden in the other mode never show and never interrupt
   function automatic logic [7:0] view();
      return wave_m ? 8'h9D : 8'hF3;
   endfunction
   function automatic logic [31:0] sr_exp(input logic [7:0] f);
      return {13'h0000, wave_m ? lb_m : pin_b, wave_m ? core.wave_a_level : pin_a,
         core.clk_running, 8'h00, f & view()};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ==========================================================
   // Bus cycles; one idle cycle between strobes keeps drivers single-assigned
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      bus.addr <= a;
      bus.wdata <= wd;
      bus.wr <= 1'b1;
      @(posedge clk_i);
      bus.wr <= 1'b0;
      #1;
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic ovf, output logic [31:0] rd);
      @(posedge clk_i);
      bus.addr <= a;
      bus.rd <= 1'b1;
      core.overflow <= ovf;
      @(posedge clk_i);
      bus.rd <= 1'b0;
      core.overflow <= 1'b0;
      #1 rd = rdata;
   endtask
   task automatic check_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus_rd(a, 1'b0, d);
      chk(what, exp, d);
   endtask
   // Status read; an event in the read cycle survives the clear
   task automatic rd_sr(input string what, input logic ovf);
      bus_rd(`TC_OFS_SR, ovf, d);
      chk(what, sr_exp(flags_m), d);
      flags_m = {7'h00, ovf};
      chk("irq", 32'(|(flags_m & ien_m & view())), 32'(irq));
   endtask
   // Core pulses p = {tick, overflow, load_a, load_b, ext_trig}
   task automatic evt(input logic [15:0] cnt, input logic [4:0] p);
      @(posedge clk_i);
      core.count <= cnt;
      {core.tick, core.overflow, core.load_a, core.load_b, core.ext_trig} <= p;
      @(posedge clk_i);
      {core.tick, core.overflow, core.load_a, core.load_b, core.ext_trig} <= 5'h00;
      #1;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Watchdog, far beyond the roughly 135 cycles the tests need
   initial begin
      #40000;
      errors++;
      give_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      bus = '0;
      core = '0;
      reset_i = 1'b1;
      rnd = lfsr(16'h000F);
      {core.clk_running, core.wave_a_level, pin_a, pin_b} = rnd[3:0];
      {flags_m, ien_m, wave_m, lb_m} = '0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      // Reset state, unmapped and write-only reads
      chk("line_b_oe", 32'h0, 32'(line_b_oe));
      check_rd("imr_rst", `TC_OFS_IMR, 32'h0);
      check_rd("ier_rd", `TC_OFS_IER, 32'h0);
      check_rd("unmapped", 8'h3C, 32'h0);
      rnd = lfsr(rnd);
      evt(rnd, 5'h00);
      check_rd("count", `TC_OFS_COUNT, {16'h0000, rnd});
      $display("test reset done");
      // Capture mode: A and B refuse writes, C takes them
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         bus_wr(`TC_OFS_CMP_A + 8'(4 * i), {~rnd, rnd});
         check_rd("cmp_capt", `TC_OFS_CMP_A + 8'(4 * i), (i == 2) ? {16'h0000, rnd} : 32'h0);
      end
      bus_wr(`TC_OFS_CTRL, 32'h1);
      wave_m = 1'b1;
      chk("wave_mode", 32'h1, 32'(wave_mode));
      chk("line_b_oe", 32'h1, 32'(line_b_oe));
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         cmp[i] = rnd;
         bus_wr(`TC_OFS_CMP_A + 8'(4 * i), {rnd, rnd});
         check_rd("cmp_wave", `TC_OFS_CMP_A + 8'(4 * i), {16'h0000, rnd});
      end
      $display("test compare access done");
      // Waveform flags: matches, overflow, trigger; loads refused
      for (int i = 0; i < 3; i++) begin
         evt(cmp[i], 5'h10);
         flags_m |= 8'h04 << i;
      end
      evt(cmp[2], 5'h0F);
      flags_m |= 8'h81;
      rd_sr("sr_wave", 1'b0);
      rd_sr("sr_clear", 1'b0);
      $display("test wave flags done");
      // Enables, disables, mask readback, interrupt level
      rnd = lfsr(rnd);
      bus_wr(`TC_OFS_IER, {rnd, rnd});
      ien_m |= rnd[7:0];
      check_rd("imr_en", `TC_OFS_IMR, {24'h0, ien_m});
      rnd = lfsr(rnd);
      bus_wr(`TC_OFS_IDR, {rnd, rnd});
      ien_m &= ~rnd[7:0];
      check_rd("imr_dis", `TC_OFS_IMR, {24'h0, ien_m});
      bus_wr(`TC_OFS_IER, 32'h1);
      ien_m |= 8'h01;
      evt(cmp[2], 5'h08);
      flags_m |= 8'h01;
      chk("irq_on", 32'h1, 32'(irq));
      rd_sr("sr_irq", 1'b0);
      bus_wr(`TC_OFS_IDR, 32'h1);
      ien_m &= 8'hFE;
      evt(cmp[2], 5'h08);
      flags_m |= 8'h01;
      chk("irq_off", 32'(|(flags_m & ien_m & view())), 32'(irq));
      rd_sr("sr_irq2", 1'b0);
      $display("test interrupt done");
      // Software trigger effects on line_b, every code
      for (int i = 0; i < 5; i++) begin
         logic [1:0] eff;
         eff = (i == 0) ? 2'h1 : (i == 1) ? 2'h0 : (i == 2) ? 2'h2 : 2'h3;
         bus_wr(`TC_OFS_CTRL, {28'h0, eff, 2'h1});
         bus_wr(`TC_OFS_CMD, 32'h1);
         lb_m = (eff == 2'h1) ? 1'b1 : (eff == 2'h2) ? 1'b0 : (eff == 2'h3) ? ~lb_m : lb_m;
         chk("line_b", 32'(lb_m), 32'(line_b));
      end
      rd_sr("sr_line_b", 1'b0);
      $display("test soft trigger done");
      // Capture mode: loads, double load, gated matches, refused write
      bus_wr(`TC_OFS_CTRL, 32'h0);
      wave_m = 1'b0;
      rnd = lfsr(rnd);
      evt(rnd, 5'h04);
      check_rd("cap_a", `TC_OFS_CMP_A, {16'h0000, rnd});
      v = rnd + 16'h0002;
      evt(rnd + 16'h0001, 5'h04);
      evt(v, 5'h04);
      evt(rnd + 16'h0003, 5'h02);
      evt(v, 5'h10);
      evt(cmp[2], 5'h11);
      flags_m |= 8'hF2;
      rd_sr("sr_capt", 1'b0);
      bus_wr(`TC_OFS_CMP_A, 32'h0000FFFF);
      check_rd("a_ro", `TC_OFS_CMP_A, {16'h0000, v});
      check_rd("cap_b", `TC_OFS_CMP_B, {16'h0000, rnd + 16'h0003});
      rd_sr("sr_race", 1'b1);
      rd_sr("sr_kept", 1'b0);
      // Clear register drops only the bits written with one
      evt(cmp[2], 5'h09);
      flags_m |= 8'h81;
      bus_wr(`TC_OFS_ICR, 32'h80);
      flags_m &= 8'h7F;
      rd_sr("sr_icr", 1'b0);
      $display("test capture flags done");
      // Second reset in mid-run
      @(posedge clk_i);
      reset_i <= 1'b1;
      {core.clk_running, pin_a, pin_b} <= ~{core.clk_running, pin_a, pin_b};
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      {flags_m, ien_m, wave_m, lb_m} = '0;
      check_rd("imr_rst2", `TC_OFS_IMR, 32'h0);
      rd_sr("sr_rst2", 1'b0);
      $display("test second reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
